/* dsp_defines.vh */
// Constants for the debug and boundary-scan port selector
`ifndef DSP_DEFINES_VH
`define DSP_DEFINES_VH
`define DSP_TAP_RESET      4'h0
`define DSP_TAP_IDLE       4'h1
`define DSP_TAP_SEL_DR     4'h2
`define DSP_TAP_CAP_DR     4'h3
`define DSP_TAP_SHIFT_DR   4'h4
`define DSP_TAP_EXIT1_DR   4'h5
`define DSP_TAP_PAUSE_DR   4'h6
`define DSP_TAP_EXIT2_DR   4'h7
`define DSP_TAP_UPD_DR     4'h8
`define DSP_TAP_SEL_IR     4'h9
`define DSP_TAP_CAP_IR     4'hA
`define DSP_TAP_SHIFT_IR   4'hB
`define DSP_TAP_EXIT1_IR   4'hC
`define DSP_TAP_PAUSE_IR   4'hD
`define DSP_TAP_EXIT2_IR   4'hE
`define DSP_TAP_UPD_IR     4'hF
`define DSP_IR_W           2
`define DSP_IR_CAPTURE     2'h1
`define DSP_IR_BYPASS      2'h3
`define DSP_IR_EXTEST      2'h0
`define DSP_IR_SAMPLE      2'h2
`define DSP_BSR_W          8
`endif

/* dsp_sync2.v */
// Two-flop synchroniser for a group of asynchronous inputs
`default_nettype none
module dsp_sync2 #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         reset_n,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);
    reg [W-1:0] meta_q;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q   <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // dsp_sync2
`default_nettype wire

/* dsp_port_select.v */
// Test pin routing, boundary-scan TAP and tick-timer halt control
// Overview of operation
// - A low reset pin routes the test pins to the boundary-scan TAP, a high one to serial debug.
// - Serial wire debug stays disabled while the device is held in reset.
// - Power-on, brown-out or a low test reset forces the TAP into Test-Logic-Reset.
// - The first test clock edge with the reset pin high moves the TAP to Run-Test/Idle.
// - The boundary-scan TAP offers scan testing only and no processor debug access.
// - In a debug session with the reset pin high the tick timer halts whenever the processor is halted.
// - Scan output data changes on the falling edge of the test clock.
`default_nettype none
`include "dsp_defines.vh"
module dsp_port_select (
    input  wire                  clk,
    input  wire                  reset_n,
    input  wire                  ext_reset_pin_n,
    input  wire                  brownout_detect_reset,
    input  wire                  test_clk,
    input  wire                  test_mode_sel,
    input  wire                  test_data_in,
    input  wire                  test_reset_n,
    input  wire                  debug_session,
    input  wire                  cpu_halted,
    input  wire [`DSP_BSR_W-1:0] bsr_pins_in,
    output reg                   test_data_out,
    output reg                   test_data_out_oe,
    output reg                   swd_enable,
    output reg                   scan_select,
    output reg                   system_tick_timer_halt,
    output reg  [`DSP_BSR_W-1:0] bsr_pins_out,
    output reg                   bsr_extest,
    output reg  [3:0]            tap_state
);
    wire [5:0] sync_w;
    // Pins come from outside the clock domain; test clock is sampled, not used as a clock
    dsp_sync2 #(.W(6)) u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in ({ext_reset_pin_n, brownout_detect_reset, test_clk, test_mode_sel,
                    test_data_in, test_reset_n}),
        .sync_out (sync_w)
    );
    wire rst_pin_s = sync_w[5];
    wire bod_s     = sync_w[4];
    wire tck_s     = sync_w[3];
    wire tms_s     = sync_w[2];
    wire tdi_s     = sync_w[1];
    wire trst_n_s  = sync_w[0];

    wire [`DSP_BSR_W-1:0] bsr_pins_s;
    // Pin levels for Capture-DR arrive unclocked as well, so they get their own two flops
    dsp_sync2 #(.W(`DSP_BSR_W)) u_sync_bsr (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in (bsr_pins_in),
        .sync_out (bsr_pins_s)
    );

    reg  [1:0]            sync_vld_q;
    reg                   tck_prev_q;
    reg  [3:0]            state_q;
    reg  [3:0]            state_d;
    reg  [`DSP_IR_W-1:0]  ir_shift_q;
    reg  [`DSP_IR_W-1:0]  ir_q;
    reg  [`DSP_BSR_W-1:0] bsr_shift_q;
    reg                   bypass_q;
    reg                   tdo_next_q;

    wire tck_rise = tck_s & ~tck_prev_q;
    wire tck_fall = ~tck_s & tck_prev_q;
    wire tap_force_reset = bod_s | ~trst_n_s;
    wire sel_bypass = (ir_q == `DSP_IR_BYPASS);
    // The synchronisers read zero for two clocks after reset, which looks like a low reset
    // pin; routing waits for real pin levels so scan mode never flashes on at start-up
    wire sync_ok    = sync_vld_q[1];

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_vld_q <= 2'h0;
        end else begin
            sync_vld_q <= {sync_vld_q[0], 1'b1};
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tck_prev_q <= 1'b0;
        end else begin
            tck_prev_q <= tck_s;
        end
    end

    // Standard sixteen-state next-state table
    always @* begin
        case (state_q)
            `DSP_TAP_RESET:    state_d = tms_s ? `DSP_TAP_RESET    : `DSP_TAP_IDLE;
            `DSP_TAP_IDLE:     state_d = tms_s ? `DSP_TAP_SEL_DR   : `DSP_TAP_IDLE;
            `DSP_TAP_SEL_DR:   state_d = tms_s ? `DSP_TAP_SEL_IR   : `DSP_TAP_CAP_DR;
            `DSP_TAP_CAP_DR:   state_d = tms_s ? `DSP_TAP_EXIT1_DR : `DSP_TAP_SHIFT_DR;
            `DSP_TAP_SHIFT_DR: state_d = tms_s ? `DSP_TAP_EXIT1_DR : `DSP_TAP_SHIFT_DR;
            `DSP_TAP_EXIT1_DR: state_d = tms_s ? `DSP_TAP_UPD_DR   : `DSP_TAP_PAUSE_DR;
            `DSP_TAP_PAUSE_DR: state_d = tms_s ? `DSP_TAP_EXIT2_DR : `DSP_TAP_PAUSE_DR;
            `DSP_TAP_EXIT2_DR: state_d = tms_s ? `DSP_TAP_UPD_DR   : `DSP_TAP_SHIFT_DR;
            `DSP_TAP_UPD_DR:   state_d = tms_s ? `DSP_TAP_SEL_DR   : `DSP_TAP_IDLE;
            `DSP_TAP_SEL_IR:   state_d = tms_s ? `DSP_TAP_RESET    : `DSP_TAP_CAP_IR;
            `DSP_TAP_CAP_IR:   state_d = tms_s ? `DSP_TAP_EXIT1_IR : `DSP_TAP_SHIFT_IR;
            `DSP_TAP_SHIFT_IR: state_d = tms_s ? `DSP_TAP_EXIT1_IR : `DSP_TAP_SHIFT_IR;
            `DSP_TAP_EXIT1_IR: state_d = tms_s ? `DSP_TAP_UPD_IR   : `DSP_TAP_PAUSE_IR;
            `DSP_TAP_PAUSE_IR: state_d = tms_s ? `DSP_TAP_EXIT2_IR : `DSP_TAP_PAUSE_IR;
            `DSP_TAP_EXIT2_IR: state_d = tms_s ? `DSP_TAP_UPD_IR   : `DSP_TAP_SHIFT_IR;
            `DSP_TAP_UPD_IR:   state_d = tms_s ? `DSP_TAP_SEL_DR   : `DSP_TAP_IDLE;
            default:           state_d = `DSP_TAP_RESET;
        endcase
        // With the reset pin high, the first edge parks the TAP in idle
        if (rst_pin_s) begin
            state_d = `DSP_TAP_IDLE;
        end
    end

    // TAP state and shift paths move on the rising test clock edge
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q     <= `DSP_TAP_RESET;
            ir_shift_q  <= {`DSP_IR_W{1'b0}};
            ir_q        <= `DSP_IR_BYPASS;
            bsr_shift_q <= {`DSP_BSR_W{1'b0}};
            bypass_q    <= 1'b0;
        end else if (tap_force_reset) begin
            state_q <= `DSP_TAP_RESET;
            ir_q    <= `DSP_IR_BYPASS;
        end else if (tck_rise) begin
            state_q <= state_d;
            case (state_q)
                `DSP_TAP_RESET: begin
                    ir_q <= `DSP_IR_BYPASS;
                end
                `DSP_TAP_CAP_IR: begin
                    ir_shift_q <= `DSP_IR_CAPTURE;
                end
                `DSP_TAP_SHIFT_IR: begin
                    ir_shift_q <= {tdi_s, ir_shift_q[`DSP_IR_W-1:1]};
                end
                `DSP_TAP_UPD_IR: begin
                    ir_q <= ir_shift_q;
                end
                `DSP_TAP_CAP_DR: begin
                    bsr_shift_q <= bsr_pins_s;
                    bypass_q    <= 1'b0;
                end
                `DSP_TAP_SHIFT_DR: begin
                    if (sel_bypass) begin
                        bypass_q <= tdi_s;
                    end else begin
                        bsr_shift_q <= {tdi_s, bsr_shift_q[`DSP_BSR_W-1:1]};
                    end
                end
                default: begin
                    bypass_q <= bypass_q;
                end
            endcase
        end
    end

    // Next serial bit is picked a clock early so the falling edge only has to copy it
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tdo_next_q <= 1'b0;
        end else begin
            tdo_next_q <= (state_q == `DSP_TAP_SHIFT_IR) ? ir_shift_q[0] :
                          (sel_bypass ? bypass_q : bsr_shift_q[0]);
        end
    end

    // Output stage: serial data updates on the falling test clock edge
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            test_data_out          <= 1'b0;
            test_data_out_oe       <= 1'b0;
            bsr_pins_out           <= {`DSP_BSR_W{1'b0}};
        end else begin
            if (tck_fall) begin
                test_data_out    <= tdo_next_q;
                test_data_out_oe <= ~rst_pin_s &
                                    ((state_q == `DSP_TAP_SHIFT_DR) |
                                     (state_q == `DSP_TAP_SHIFT_IR));
            end
            // The pin is let go at once when scan mode ends or the TAP is forced to reset
            if (rst_pin_s | tap_force_reset) begin
                test_data_out_oe <= 1'b0;
            end
            if ((state_q == `DSP_TAP_UPD_DR) && !sel_bypass) begin
                bsr_pins_out <= bsr_shift_q;
            end
        end
    end

    // Routing and tick-timer halt are plain levels, kept apart from the serial path
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            swd_enable             <= 1'b0;
            scan_select            <= 1'b0;
            system_tick_timer_halt <= 1'b0;
            bsr_extest             <= 1'b0;
            tap_state              <= `DSP_TAP_RESET;
        end else begin
            scan_select <= sync_ok & ~rst_pin_s;
            // Debug port only with reset released and no brown-out pending
            swd_enable  <= sync_ok & rst_pin_s & ~bod_s;
            // Scan path has no route into the processor; halt comes only via serial debug
            system_tick_timer_halt <= debug_session & cpu_halted &
                                      rst_pin_s;
            bsr_extest <= sync_ok & ~rst_pin_s & (ir_q == `DSP_IR_EXTEST);
            tap_state  <= state_q;
        end
    end
endmodule // dsp_port_select
`default_nettype wire

/* dsp_port_select_sva.sv */
// Assertions on the pins of the port selector
`default_nettype none
`include "dsp_defines.vh"
module dsp_port_select_sva (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       ext_reset_pin_n,
    input wire logic       brownout_detect_reset,
    input wire logic       test_clk,
    input wire logic       test_reset_n,
    input wire logic       debug_session,
    input wire logic       cpu_halted,
    input wire logic       test_data_out,
    input wire logic       test_data_out_oe,
    input wire logic       swd_enable,
    input wire logic       scan_select,
    input wire logic       system_tick_timer_halt,
    input wire logic [3:0] tap_state
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Windows of two to eight cycles (five on the routing checks) cover the two-flop lag on the pins
    AST_ROUTE_SCAN: assert property (!ext_reset_pin_n [*5] |-> scan_select)
        else $error("pins not routed to scan with reset pin low");
    AST_ROUTE_SWD: assert property (
        (ext_reset_pin_n && !brownout_detect_reset) [*5] |-> swd_enable && !scan_select)
        else $error("serial debug not selected with reset pin high");
    AST_SWD_OFF: assert property (
        (!ext_reset_pin_n || brownout_detect_reset) [*5] |-> !swd_enable)
        else $error("serial debug enabled while in reset");
    AST_TLR: assert property (
        (!test_reset_n || brownout_detect_reset) [*8] |-> tap_state == `DSP_TAP_RESET)
        else $error("tap not held in reset");
    AST_IDLE: assert property (
        ((ext_reset_pin_n && test_reset_n && !brownout_detect_reset) [*8] ##0 $rose(test_clk))
        |-> ##[1:8] tap_state == `DSP_TAP_IDLE)
        else $error("tap not idle after test clock with reset pin high");
    AST_OE_SCAN: assert property (test_data_out_oe |-> scan_select)
        else $error("scan output driven outside scan mode");
    AST_TICK_HALT: assert property (
        (debug_session && cpu_halted && ext_reset_pin_n) [*4] |-> system_tick_timer_halt)
        else $error("tick timer runs while core halted");
    AST_TICK_RUN: assert property (!cpu_halted [*2] |-> !system_tick_timer_halt)
        else $error("tick timer halted while core runs");
    AST_TDO_FALL: assert property (
        $changed(test_data_out) |-> !$past(test_clk, 2) || !$past(test_clk, 3))
        else $error("scan output changed away from a falling test clock");
    AST_TAP_HOLD: assert property (
        (!test_clk && test_reset_n && !brownout_detect_reset) [*6] |-> $stable(tap_state))
        else $error("tap moved without a rising test clock");
endmodule // dsp_port_select_sva
`default_nettype wire

/* dsp_tester.sv */
// Model of the external boundary-scan tester at the test pins
`default_nettype none
module dsp_tester (
    input  wire logic clk,
    input  wire logic test_data_out,
    output var  logic ext_reset_pin_n,
    output var  logic test_clk,
    output var  logic test_mode_sel,
    output var  logic test_data_in,
    output var  logic test_reset_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // Flash holds no user code in this model, so nothing is left to erase
    // Bootloader entry pin stays released; lock-out recovery is not exercised
    initial begin
        ext_reset_pin_n = 1'b1; // Powered up with reset high
        test_clk = 1'b0;
        test_mode_sel = 1'b1; // Pull-up levels until the first frame
        test_data_in = 1'b1;
        test_reset_n = 1'b1;
    end
    // Clock stands low between frames; TMS and TDI settle well before the rise
    task automatic tick(input logic m, input logic d, output logic q);
        @(negedge clk);
        test_mode_sel = m;
        test_data_in = d;
        repeat (3) @(negedge clk);
        q = test_data_out;
        test_clk = 1'b1;
        repeat (4) @(negedge clk);
        test_clk = 1'b0;
    endtask
    task automatic set_pins(input logic rst_n, input logic trst_n);
        @(negedge clk);
        ext_reset_pin_n = rst_n;
        test_reset_n = trst_n;
        repeat (9) @(negedge clk);
    endtask
endmodule // dsp_tester
`default_nettype wire

/* dsp_port_select_test.sv */
// Self-checking bench for the debug and scan port selector
`default_nettype none
`include "dsp_defines.vh"
module dsp_port_select_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset_n, brownout_detect_reset, debug_session, cpu_halted;
    logic ext_reset_pin_n, test_clk, test_mode_sel, test_data_in, test_reset_n;
    logic test_data_out, test_data_out_oe, swd_enable, scan_select;
    logic system_tick_timer_halt, bsr_extest;
    logic [7:0] bsr_pins_in, bsr_pins_out;
    logic [3:0] tap_state;
    int n_errors = 0;
    int n_compared = 0;
    dsp_port_select DUT (.clk, .reset_n, .ext_reset_pin_n, .brownout_detect_reset, .test_clk,
        .test_mode_sel, .test_data_in, .test_reset_n, .debug_session, .cpu_halted,
        .bsr_pins_in, .test_data_out, .test_data_out_oe, .swd_enable, .scan_select,
        .system_tick_timer_halt, .bsr_pins_out, .bsr_extest, .tap_state);
    dsp_tester tester (.clk, .test_data_out, .ext_reset_pin_n, .test_clk, .test_mode_sel,
        .test_data_in, .test_reset_n);
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("Counts: %0d mismatches in %0d compared", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic moves(input logic [7:0] m, input int n);
        logic q;
        for (int i = 0; i < n; i++) tester.tick(m[i], 1'b1, q);
    endtask
    task automatic test_swd_mode();
        moves(8'h01, 1); // TMS high still lands in idle with reset pin high
        chk("tap_state", {4'h0, `DSP_TAP_IDLE}, {4'h0, tap_state});
        chk("swd_on", {7'h00, 1'b1}, {7'h00, swd_enable && !scan_select});
    endtask
    task automatic test_tick_halt();
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            {debug_session, cpu_halted} = i[1:0];
            repeat (3) @(negedge clk);
            chk("tick_halt", {7'h00, i == 3}, {7'h00, system_tick_timer_halt});
        end
    endtask
    task automatic test_scan();
        logic [7:0] got;
        logic [7:0] pat;
        pat = 8'h3C;
        tester.set_pins(1'b0, 1'b1); // Scan entry after the power-up wait
        chk("scan_sel", 8'h01, {7'h00, scan_select && !swd_enable});
        moves(8'h03, 4); // Idle to Shift-IR, then load EXTEST LSB first
        tester.tick(1'b0, 1'b0, got[0]);
        tester.tick(1'b1, 1'b0, got[0]);
        moves(8'h05, 5); // Update-IR, idle, then Select, Capture, Shift-DR
        repeat (4) @(negedge clk);
        chk("oe_shift", 8'h01, {7'h00, test_data_out_oe});
        for (int i = 0; i < 8; i++) tester.tick(i == 7, pat[i], got[i]);
        moves(8'h01, 2);
        chk("tdo_bits", bsr_pins_in, got);
        chk("bsr_out", 8'h3C, bsr_pins_out);
        chk("extest", 8'h01, {7'h00, bsr_extest});
        chk("oe_idle", 8'h00, {7'h00, test_data_out_oe});
    endtask
    task automatic test_bypass();
        logic [2:0] byp;
        moves(8'h03, 4); // Idle to Shift-IR, then load BYPASS
        tester.tick(1'b0, 1'b1, byp[0]);
        tester.tick(1'b1, 1'b1, byp[0]);
        moves(8'h05, 5);
        for (int i = 0; i < 3; i++) tester.tick(i == 2, i == 0, byp[i]);
        moves(8'h01, 2);
        chk("byp_bits", 8'h02, {5'h00, byp});
        chk("byp_bsr", 8'h3C, bsr_pins_out);
        chk("byp_extest", 8'h00, {7'h00, bsr_extest});
    endtask
    task automatic test_exit();
        tester.set_pins(1'b0, 1'b0); // Test reset before releasing reset pin
        chk("tap_trst", 8'h00, {4'h0, tap_state});
        tester.set_pins(1'b1, 1'b0);
        chk("swd_back", 8'h01, {7'h00, swd_enable});
        tester.set_pins(1'b1, 1'b1);
        test_swd_mode();
        brownout_detect_reset = 1'b1;
        repeat (10) @(negedge clk);
        chk("tap_bod", 8'h00, {4'h0, tap_state});
        chk("swd_bod", 8'h00, {7'h00, swd_enable});
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        reset_n = 1'b0;
        {brownout_detect_reset, debug_session, cpu_halted} = 3'h0;
        bsr_pins_in = 8'hA5;
        repeat (20) @(negedge clk);
        chk("swd_in_reset", 8'h00, {7'h00, swd_enable});
        reset_n = 1'b1;
        repeat (6) @(negedge clk);
        test_swd_mode();
        test_tick_halt();
        repeat (25000) @(negedge clk); // Full power-up wait kept in earnest
        test_scan();
        test_bypass();
        test_exit();
        finish_test();
    end
    initial begin
        #400us;
        n_errors++;
        finish_test();
    end
endmodule // dsp_port_select_test
bind dsp_port_select dsp_port_select_sva chk_i (.clk, .reset_n, .ext_reset_pin_n,
    .brownout_detect_reset, .test_clk, .test_reset_n, .debug_session, .cpu_halted,
    .test_data_out, .test_data_out_oe, .swd_enable, .scan_select, .system_tick_timer_halt,
    .tap_state);
`default_nettype wire
